// ### rtl/wkpsel_edge.sv
/*
  Rising edge detector with a sticky flag, cleared by writing a one.
  Assumes the event input is synchronous to the clock.
*/
module wkpsel_edge
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic event_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic prev;

  // previous level for edge finding
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      prev <= 1'b0;
    else
      prev <= event_i;
  end

  // sticky flag, a new edge wins over a clear
  always_ff @(posedge clk_i)
  begin
    if (!nrst_i)
      flag_o <= 1'b0;
    else if (event_i && !prev)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end

endmodule

// ### rtl/wkpsel_mux.sv
/*
  Channel selector: picks one of three channel signals by the two
  channel select bits. Code 1/1 gives a defined low.
  Assumes inputs synchronous to the clock; output is combinational.
*/
module wkpsel_mux
(
  input wire logic [2:0] chan_i,
  input wire logic [1:0] sel_i,
  output logic pick_o
);

  // 0/0 first, 0/1 second, 1/0 third, 1/1 low
  always_comb
  begin
    unique case (sel_i)
      2'b00: pick_o = chan_i[0];
      2'b01: pick_o = chan_i[1];
      2'b10: pick_o = chan_i[2];
      2'b11: pick_o = 1'b0;
    endcase
  end

endmodule

// ### rtl/wkpsel_pkg.sv
/*
  Shared constants of the wakeup output pin selector: register
  offsets, field positions, reset values and interrupt bit layout.
  Assumes a 40 MHz core clock and a plain strobe register port.
*/
package wkpsel_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] ADDR_TEST_MODE = 8'h00;
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h04;
  localparam logic [7:0] ADDR_CORR_CFG = 8'h08;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int TEST_ROUTE_ENABLE_BIT = 0;
  localparam int TEST_SELECT_LOW_BIT = 1;
  localparam int TEST_SELECT_HIGH_BIT = 2;
  localparam int CHAN_SELECT_LOW_BIT = 0;
  localparam int CHAN_SELECT_HIGH_BIT = 1;
  localparam int STRENGTH_MODE_LOW_BIT = 2;
  localparam int STRENGTH_MODE_HIGH_BIT = 3;
  localparam int ERR_TOL_LSB = 0;
  localparam int THRESHOLD_TAU_BIT = 4;

  // ****************************************************************
  // widths and reset values
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CHANNELS = 3;
  localparam int IRQ_W = 4;
  localparam logic [2:0] TEST_MODE_RESET = 3'h0;
  localparam logic [3:0] CHAN_SEL_RESET = 4'h0;
  localparam logic [1:0] ERR_TOL_RESET = 2'h0;
  localparam logic [1:0] ERR_TOL_MAX = 2'h2;
  localparam logic THRESHOLD_TAU_RESET = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  // interrupt bits: one per channel detect rise, bit 3 combined detect
  localparam int IRQ_COMBINED_BIT = 3;

endpackage

// ### rtl/wkpsel_top.sv
/*
  Wakeup output pin selector: routes combined detect, per-channel
  detect or per-channel bitstream to the wake pin and to the
  strength pin, holds correlator tolerance and threshold filter
  settings, and raises an interrupt on detect events.
  Assumes one 40 MHz clock, synchronous active low reset, and a
  strobe register port with read data one cycle after the strobe.
  The strength pin enable is meant for a pad that is released while
  low; outside digital mode the pin value is a one-bit stand-in for
  the analog level, passed through with one cycle of lag.
*/
// Local design decisions: the address-and-strobe port and the register offsets.
module wkpsel_top
(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic [wkpsel_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [wkpsel_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [wkpsel_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [2:0] CHAN_BITSTREAM_I,
  input wire logic [2:0] CHAN_DETECT_I,
  input wire logic CHIP_SELECT_I,
  input wire logic ANALOG_STRENGTH_I,
  output logic WAKE_O,
  output logic STRENGTH_O,
  output logic STRENGTH_OE_O,
  output logic STRENGTH_DIGITAL_O,
  output logic [1:0] ERR_TOL_O,
  output logic THRESHOLD_TAU_O,
  output logic IRQ_O
);

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic test_route_enable;
  logic test_select_low;
  logic test_select_high;
  logic chan_select_low;
  logic chan_select_high;
  logic strength_out_mode_low;
  logic strength_out_mode_high;
  logic [1:0] err_tol;
  logic threshold_tau_select;
  logic [wkpsel_pkg::IRQ_W-1:0] irq_mask;
  logic [wkpsel_pkg::IRQ_W-1:0] irq_status;
  logic [wkpsel_pkg::IRQ_W-1:0] irq_clear;
  logic [1:0] wr_tol;

  // ****************************************************************
  // write decode
  // ****************************************************************
  logic wr_test;
  logic wr_chan;
  logic wr_corr;
  logic wr_mask;
  logic wr_stat;

  // one strobe per writable register (pin state has none), unmapped offsets decode to nothing
  assign wr_test = WR_I && (ADDR_I == wkpsel_pkg::ADDR_TEST_MODE);
  assign wr_chan = WR_I && (ADDR_I == wkpsel_pkg::ADDR_CHAN_SEL);
  assign wr_corr = WR_I && (ADDR_I == wkpsel_pkg::ADDR_CORR_CFG);
  assign wr_mask = WR_I && (ADDR_I == wkpsel_pkg::ADDR_IRQ_MASK);
  assign wr_stat = WR_I && (ADDR_I == wkpsel_pkg::ADDR_IRQ_STATUS);

  // test mode register, all three bits load in one write so the
  // route never passes through a half-written code
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      test_route_enable <= wkpsel_pkg::TEST_MODE_RESET[0];
      test_select_low <= wkpsel_pkg::TEST_MODE_RESET[1];
      test_select_high <= wkpsel_pkg::TEST_MODE_RESET[2];
    end
    else if (wr_test)
    begin
      test_route_enable <= WDATA_I[wkpsel_pkg::TEST_ROUTE_ENABLE_BIT];
      test_select_low <= WDATA_I[wkpsel_pkg::TEST_SELECT_LOW_BIT];
      test_select_high <= WDATA_I[wkpsel_pkg::TEST_SELECT_HIGH_BIT];
    end
  end

  // channel select register, channel code and strength mode
  // load together
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      chan_select_low <= wkpsel_pkg::CHAN_SEL_RESET[0];
      chan_select_high <= wkpsel_pkg::CHAN_SEL_RESET[1];
      strength_out_mode_low <= wkpsel_pkg::CHAN_SEL_RESET[2];
      strength_out_mode_high <= wkpsel_pkg::CHAN_SEL_RESET[3];
    end
    else if (wr_chan)
    begin
      chan_select_low <= WDATA_I[wkpsel_pkg::CHAN_SELECT_LOW_BIT];
      chan_select_high <= WDATA_I[wkpsel_pkg::CHAN_SELECT_HIGH_BIT];
      strength_out_mode_low <= WDATA_I[wkpsel_pkg::STRENGTH_MODE_LOW_BIT];
      strength_out_mode_high <= WDATA_I[wkpsel_pkg::STRENGTH_MODE_HIGH_BIT];
    end
  end

  // tolerance field; each step lets one more invalid zero half-bit
  // pass, trading false-wake immunity for reach, so values above
  // the maximum saturate rather than wrap to zero
  assign wr_tol = WDATA_I[wkpsel_pkg::ERR_TOL_LSB +: 2];

  // correlator and threshold filter settings
  // tau resets to the large constant, the noise-robust choice
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      err_tol <= wkpsel_pkg::ERR_TOL_RESET;
      threshold_tau_select <= wkpsel_pkg::THRESHOLD_TAU_RESET;
    end
    else if (wr_corr)
    begin
      err_tol <= (wr_tol > wkpsel_pkg::ERR_TOL_MAX) ? wkpsel_pkg::ERR_TOL_MAX : wr_tol;
      threshold_tau_select <= WDATA_I[wkpsel_pkg::THRESHOLD_TAU_BIT];
    end
  end

  // interrupt mask register, a one lets that status bit
  // raise the interrupt line
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
      irq_mask <= wkpsel_pkg::IRQ_MASK_RESET;
    else if (wr_mask)
      irq_mask <= WDATA_I[wkpsel_pkg::IRQ_W-1:0];
  end

  // ****************************************************************
  // signal routing
  // ****************************************************************
  logic combined_detect;
  logic pick_bitstream;
  logic pick_detect;
  logic strength_digital;
  logic strength_sel;
  logic wake_sel;
  logic [1:0] test_sel;
  logic [1:0] chan_sel;
  logic route_bitstream;
  logic route_detect;
  logic chan_sel_combined;
  logic next_strength;

  // combined detect is the or of all channels, the normal wake
  // source and the strength pin's all-channel signal
  assign combined_detect = |CHAN_DETECT_I;

  // ****************************************************************
  // route code decode
  // ****************************************************************
  // select pairs as codes, upper bit first
  assign test_sel = {test_select_high, test_select_low};
  assign chan_sel = {chan_select_high, chan_select_low};

  // 0/0 routes the bitstream, 0/1 the detect; upper bit set is unlisted
  assign route_bitstream = (test_sel == 2'h0);
  assign route_detect = (test_sel == 2'h1);

  // channel code 1/1 names no single channel
  assign chan_sel_combined = (chan_sel == 2'h3);

  // detector outputs, the same that feed the correlators; both
  // muxes share one channel code so data and detect never split
  wkpsel_mux u_data_mux
  (
    .chan_i(CHAN_BITSTREAM_I),
    .sel_i(chan_sel),
    .pick_o(pick_bitstream)
  );

  // per-channel detect flags through the same channel code
  wkpsel_mux u_detect_mux
  (
    .chan_i(CHAN_DETECT_I),
    .sel_i(chan_sel),
    .pick_o(pick_detect)
  );

  // wake pin selection; route enable low always wins, so normal
  // wakeups survive any test code left behind
  always_comb
  begin
    if (!test_route_enable)
      wake_sel = combined_detect;
    else if (route_bitstream)
      wake_sel = pick_bitstream;
    else if (route_detect)
      wake_sel = pick_detect;
    else
      wake_sel = 1'b0;
  end

  assign strength_digital = strength_out_mode_high && !strength_out_mode_low;

  // strength pin selection in digital mode, route enable ignored so
  // the wake pin can stay normal while this pin shows one channel
  always_comb
  begin
    if (chan_sel_combined)
      strength_sel = combined_detect;
    else if (route_bitstream)
      strength_sel = pick_bitstream;
    else if (route_detect)
      strength_sel = pick_detect;
    else
      strength_sel = 1'b0;
  end

  // ****************************************************************
  // pin output registers
  // ****************************************************************
  // strength pin value, digital pick or the analog stand-in
  assign next_strength = strength_digital ? strength_sel : ANALOG_STRENGTH_I;

  // wake pin, one cycle behind the channel inputs
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
      WAKE_O <= 1'b0;
    else
      WAKE_O <= wake_sel;
  end

  // strength pin, same lag as the wake pin so both stay aligned
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
      STRENGTH_O <= 1'b0;
    else
      STRENGTH_O <= next_strength;
  end

  // drive the strength pin only while chip select is high; the enable
  // has no register so the pad lets go in the very cycle of deselect,
  // while the level it shows is the registered pin value; mode and
  // settings outputs come straight from their registers
  assign STRENGTH_OE_O = CHIP_SELECT_I;
  assign STRENGTH_DIGITAL_O = strength_digital;
  assign ERR_TOL_O = err_tol;
  assign THRESHOLD_TAU_O = threshold_tau_select;

  // ****************************************************************
  // interrupts
  // ****************************************************************
  // a write of ones clears those flags, zeros leave them alone; an
  // edge in the same cycle as its clear still sets the flag
  assign irq_clear = wr_stat ? WDATA_I[wkpsel_pkg::IRQ_W-1:0] : '0;

  // one sticky flag per channel, set on the rising edge of its
  // detect level so a held detect is reported once
  genvar g;
  generate
    for (g = 0; g < wkpsel_pkg::CHANNELS; g++)
    begin : g_irq
      wkpsel_edge u_edge
      (
        .clk_i(CORE_CLK_I),
        .nrst_i(NRST_I),
        .event_i(CHAN_DETECT_I[g]),
        .clear_i(irq_clear[g]),
        .flag_o(irq_status[g])
      );
    end
  endgenerate

  // combined detect flag
  wkpsel_edge u_edge_comb
  (
    .clk_i(CORE_CLK_I),
    .nrst_i(NRST_I),
    .event_i(combined_detect),
    .clear_i(irq_clear[wkpsel_pkg::IRQ_COMBINED_BIT]),
    .flag_o(irq_status[wkpsel_pkg::IRQ_COMBINED_BIT])
  );

  logic [wkpsel_pkg::IRQ_W-1:0] irq_pending;

  // unmasked flags hold the level interrupt high
  assign irq_pending = irq_status & irq_mask;
  assign IRQ_O = |irq_pending;

  // ****************************************************************
  // register read port
  // ****************************************************************
  logic [wkpsel_pkg::DATA_W-1:0] next_rdata;

  // read word select, zero outside a read slot so the bus idles low
  always_comb
  begin
    next_rdata = '0;
    if (RD_I)
    begin
      unique case (ADDR_I)
        wkpsel_pkg::ADDR_TEST_MODE:
          next_rdata = {29'h0, test_select_high, test_select_low, test_route_enable};
        wkpsel_pkg::ADDR_CHAN_SEL:
          next_rdata = {28'h0, strength_out_mode_high, strength_out_mode_low,
                        chan_select_high, chan_select_low};
        wkpsel_pkg::ADDR_CORR_CFG:
          next_rdata = {27'h0, threshold_tau_select, 2'h0, err_tol};
        wkpsel_pkg::ADDR_PIN_STATE:
          next_rdata = {30'h0, STRENGTH_O, WAKE_O};
        wkpsel_pkg::ADDR_IRQ_STATUS:
          next_rdata = {28'h0, irq_status};
        wkpsel_pkg::ADDR_IRQ_MASK:
          next_rdata = {28'h0, irq_mask};
        default:
          next_rdata = '0;
      endcase
    end
  end

  // read data register, stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
      RDATA_O <= '0;
    else
      RDATA_O <= next_rdata;
  end

endmodule

// ### tb/wakeup_output_pin_selector_test.sv
/*
  Self-checking bench of the wakeup output pin selector.
  Assumes a 40 MHz clock and registered wake and strength pins.
*/
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module wakeup_output_pin_selector_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, wr, rd, csel, astr, wake, str, str_oe, str_dig, tau, irq, wpin, spin;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [2:0] bits, det;
  logic [1:0] tol;
  int miscompares = 0;
  int n_checks = 0;
  wkpsel_top i_wkpsel_top (.CORE_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .CHAN_BITSTREAM_I(bits), .CHAN_DETECT_I(det),
    .CHIP_SELECT_I(csel), .ANALOG_STRENGTH_I(astr), .WAKE_O(wake), .STRENGTH_O(str),
    .STRENGTH_OE_O(str_oe), .STRENGTH_DIGITAL_O(str_dig), .ERR_TOL_O(tol),
    .THRESHOLD_TAU_O(tau), .IRQ_O(irq));
  wkpsel_mcu i_wkpsel_mcu (.clk_i(clk), .wake_i(wake), .strength_i(str),
    .strength_oe_i(str_oe), .wake_pin_o(wpin), .strength_pin_o(spin));
  // ************************************************************
  // bus cycles and pin stimulus
  // ************************************************************
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task pins(input logic [2:0] b, input logic [2:0] t);
    @(posedge clk);
    bits <= b; det <= t; astr <= ~astr;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    `CHK("tau after reset", 1'b1, tau)
    rd_reg(wkpsel_pkg::ADDR_CORR_CFG);
    `CHK("corr word", 32'h0000_0010, d)
    rd_reg(8'h20);
    `CHK("unmapped read", 32'h0000_0000, d)
  endtask
  task t_wake;
    logic [2:0] oh;
    for (int c = 0; c < 3; c++)
      for (int p = 0; p < 2; p++)
      begin
        oh = p ? ~(3'h1 << c) : 3'h1 << c;
        wr_reg(wkpsel_pkg::ADDR_CHAN_SEL, 32'(c));
        wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h1);
        pins(oh, ~oh);
        `CHK("wake data", oh[c], wpin)
        wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h3);
        pins(oh, ~oh);
        `CHK("wake detect", ~oh[c], wpin)
        wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h6);
        `CHK("wake combined", 1'b1, wpin)
        pins(oh, 3'h0);
        `CHK("wake combined idle", 1'b0, wpin)
        wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h5);
        pins(3'h7, 3'h7);
        `CHK("wake bad select", 1'b0, wpin)
      end
    wr_reg(wkpsel_pkg::ADDR_CHAN_SEL, 32'h3);
    wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h1);
    `CHK("wake chan code 3", 1'b0, wpin)
  endtask
  task t_strength;
    for (int c = 0; c < 3; c++)
    begin
      wr_reg(wkpsel_pkg::ADDR_CHAN_SEL, 32'(8 + c));
      wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h0);
      pins(3'h1 << c, ~(3'h1 << c));
      `CHK("strength data", 1'b1, spin)
      wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h3);
      `CHK("strength detect", 1'b0, spin)
      wr_reg(wkpsel_pkg::ADDR_TEST_MODE, 32'h4);
      `CHK("strength bad select", 1'b0, spin)
    end
    wr_reg(wkpsel_pkg::ADDR_CHAN_SEL, 32'hB);
    pins(3'h0, 3'h2);
    `CHK("strength combined", 1'b1, spin)
    `CHK("digital flag", 1'b1, str_dig)
    rd_reg(wkpsel_pkg::ADDR_PIN_STATE);
    `CHK("pin state", 32'h0000_0003, d)
    @(posedge clk);
    csel <= 1'b0;
    #1 `CHK("released pin", 1'b0, str_oe)
    `CHK("released level", 1'b0, spin)
    @(posedge clk);
    csel <= 1'b1;
    wr_reg(wkpsel_pkg::ADDR_CHAN_SEL, 32'h4);
    `CHK("analog flag", 1'b0, str_dig)
    pins(3'h0, 3'h0);
    `CHK("analog level", astr, spin)
  endtask
  task t_corr;
    for (int v = 0; v < 4; v++)
    begin
      wr_reg(wkpsel_pkg::ADDR_CORR_CFG, 32'(16 + v));
      rd_reg(wkpsel_pkg::ADDR_CORR_CFG);
      `CHK("tolerance", v > 2 ? 2'h2 : 2'(v), tol)
      `CHK("corr readback", v > 2 ? 32'h0000_0012 : 32'(16 + v), d)
    end
    wr_reg(wkpsel_pkg::ADDR_CORR_CFG, 32'h0);
    `CHK("small tau", 1'b0, tau)
    wr_reg(wkpsel_pkg::ADDR_CORR_CFG, 32'h10);
    `CHK("large tau", 1'b1, tau)
  endtask
  task t_irq;
    pins(3'h0, 3'h0);
    wr_reg(wkpsel_pkg::ADDR_IRQ_STATUS, 32'hF);
    wr_reg(wkpsel_pkg::ADDR_IRQ_MASK, 32'h0);
    pins(3'h0, 3'h1);
    rd_reg(wkpsel_pkg::ADDR_IRQ_STATUS);
    `CHK("status", 32'h0000_0009, d)
    `CHK("masked irq", 1'b0, irq)
    wr_reg(wkpsel_pkg::ADDR_IRQ_MASK, 32'h1);
    `CHK("unmasked irq", 1'b1, irq)
    pins(3'h0, 3'h0);
    wr_reg(wkpsel_pkg::ADDR_IRQ_STATUS, 32'h9);
    `CHK("cleared irq", 1'b0, irq)
  endtask
  // ************************************************************
  // clock, run sequence and watchdog
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    give_verdict;
  end
  initial
  begin
    {nrst, wr, rd, addr, wdata, bits, det, astr} = '0;
    csel = 1'b1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_wake;
    t_strength;
    t_corr;
    t_irq;
    give_verdict;
  end
endmodule

// ### tb/wkpsel_mcu.sv
/*
  Model of the controller reading the wake and strength pins.
  Assumes the strength pin has no pull: released, it drifts.
*/
module wkpsel_mcu
(
  input wire logic clk_i,
  input wire logic wake_i,
  input wire logic strength_i,
  input wire logic strength_oe_i,
  output logic wake_pin_o,
  output logic strength_pin_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last;
  // ************************************************************
  // pin levels as the controller sees them
  // ************************************************************
  always_ff @(posedge clk_i)
    if (strength_oe_i)
      last <= strength_i;
  // released pin shows the inverse of its last driven level
  assign strength_pin_o = strength_oe_i ? strength_i : ~last;
  assign wake_pin_o = wake_i;
endmodule

// ### tb/wkpsel_props.sv
/*
  Port-level checks of the wakeup output pin selector.
  Assumes it is bound into wkpsel_top and sees only its ports.
*/
module wkpsel_props
(
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic [2:0] CHAN_BITSTREAM_I,
  input wire logic [2:0] CHAN_DETECT_I,
  input wire logic CHIP_SELECT_I,
  input wire logic WAKE_O,
  input wire logic STRENGTH_O,
  input wire logic STRENGTH_OE_O,
  input wire logic STRENGTH_DIGITAL_O,
  input wire logic [1:0] ERR_TOL_O
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] tm;
  logic [3:0] cs;
  logic [3:0] b4;
  logic [3:0] d4;
  logic pc;
  logic dig;
  logic any;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  // ************************************************************
  // shadow of the select words, taken from port writes
  // ************************************************************
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!NRST_I)
    begin
      tm <= 3'h0;
      cs <= 4'h0;
    end
    else if (WR_I && ADDR_I == wkpsel_pkg::ADDR_TEST_MODE)
      tm <= WDATA_I[2:0];
    else if (WR_I && ADDR_I == wkpsel_pkg::ADDR_CHAN_SEL)
      cs <= WDATA_I[3:0];
  end
  // expected per-channel pick, code 3 reads a low
  assign b4 = {1'b0, CHAN_BITSTREAM_I};
  assign d4 = {1'b0, CHAN_DETECT_I};
  assign pc = tm[2:1] == 2'h0 ? b4[cs[1:0]] : (tm[2:1] == 2'h1 ? d4[cs[1:0]] : 1'b0);
  assign dig = cs[3:2] == 2'h2;
  assign any = |CHAN_DETECT_I;
  sequence s_live;
    $past(NRST_I);
  endsequence
  wake_normal_a: assert property (s_live ##0 $past(!tm[0]) |->
    WAKE_O == $past(any)) else $error("wake pin not combined detect");
  wake_chan_a: assert property (s_live ##0 $past(tm[0]) |->
    WAKE_O == $past(pc)) else $error("wake pin wrong channel signal");
  str_chan_a: assert property (s_live ##0 $past(dig && cs[1:0] != 2'h3) |->
    STRENGTH_O == $past(pc)) else $error("strength pin wrong channel signal");
  str_comb_a: assert property (s_live ##0 $past(dig && cs[1:0] == 2'h3) |->
    STRENGTH_O == $past(any)) else $error("strength pin not combined detect");
  str_mode_a: assert property (STRENGTH_DIGITAL_O == dig)
    else $error("strength digital mode wrong");
  pin_drive_a: assert property (STRENGTH_OE_O == CHIP_SELECT_I)
    else $error("strength pin drive not tied to chip select");
  tol_range_a: assert property (ERR_TOL_O <= 2'h2)
    else $error("tolerance above two");
  rdata_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule

bind wkpsel_top wkpsel_props i_wkpsel_props (.*);
